// ---- bm_defs.vh ----
// Address map, field positions, reset values and timing counts of the battery monitor bank
`ifndef BM_DEFS_VH
`define BM_DEFS_VH

// ****************************************************************
// Byte indexes (page * 8 + byte); byte address is four times these
// ****************************************************************
`define BM_IDX_STATUS    6'h00
`define BM_IDX_TEMP_LO   6'h01
`define BM_IDX_TEMP_HI   6'h02
`define BM_IDX_VOLT_LO   6'h03
`define BM_IDX_VOLT_HI   6'h04
`define BM_IDX_CUR_LO    6'h05
`define BM_IDX_CUR_HI    6'h06
`define BM_IDX_THRESH    6'h07
`define BM_IDX_ETM_B0    6'h08
`define BM_IDX_ETM_B3    6'h0b
`define BM_IDX_ICA       6'h0c
`define BM_IDX_RSVD      6'h0f
`define BM_IDX_DISC      6'h10
`define BM_IDX_EOC       6'h14
`define BM_IDX_EE_FIRST  6'h18
`define BM_IDX_ACC_FIRST 6'h3c
`define BM_PAGE1         3'h1

// ****************************************************************
// Command register (word address above the 64-byte map)
// ****************************************************************
`define BM_CMD_WADDR     30'h0000_0040
`define BM_CMD_TEMP      0
`define BM_CMD_VOLT      1

// ****************************************************************
// Status/configuration byte fields and reset value
// ****************************************************************
`define BM_CFG_CUR_EN    0
`define BM_CFG_ACC_EN    1
`define BM_CFG_SHADOW    2
`define BM_CFG_VSEL      3
`define BM_CFG_TBUSY     4
`define BM_CFG_NVBUSY    5
`define BM_CFG_VBUSY     6
`define BM_STATUS_RST    4'hf
`define BM_RSVD_VALUE    8'hff

// ****************************************************************
// Timing: figures in their own units, cycle counts derived
// ****************************************************************
`define BM_CLK_HZ        200000000
`define BM_CLK_KHZ       200000
`define BM_CUR_RATE_CHZ  3641
`define BM_CUR_CYC       ((`BM_CLK_HZ / `BM_CUR_RATE_CHZ) * 100)
`define BM_VCONV_MS      10
`define BM_VCONV_CYC     (`BM_VCONV_MS * `BM_CLK_KHZ)
`define BM_TCONV_MS      10
`define BM_TCONV_CYC     (`BM_TCONV_MS * `BM_CLK_KHZ)
`define BM_NVM_MAX_MS    10
`define BM_NVM_CYC       (`BM_NVM_MAX_MS * `BM_CLK_KHZ)
`define BM_SECOND_S      1
`define BM_SECOND_CYC    (`BM_SECOND_S * `BM_CLK_HZ)

`endif

// ---- bm_busy_timer.v ----
// One-shot busy timer: a start pulse holds busy for a fixed cycle count
`timescale 1ns/1ps
module bm_busy_timer
#(
   parameter W   = 28,
   parameter CYC = 2000000
)
(
   // Clock and reset
   input  wire         hclk,
   input  wire         hresetn,
   // Control
   input  wire         start,
   output reg          busy_r,
   output reg          done_r
);

   // Reload value cut to the counter width on purpose
   localparam [31:0]  CYC_M1 = CYC - 1;
   localparam [W-1:0] LAST   = CYC_M1[W-1:0];

   reg [W-1:0] cnt_r;

   // Start while idle loads the count; a start during busy is ignored
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_r  <= {W{1'b0}};
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         if (busy_r)
         begin
            if (cnt_r == {W{1'b0}})
            begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
            else
               cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         end
         else if (start)
         begin
            cnt_r  <= LAST;
            busy_r <= 1'b1;
         end
      end
   end

endmodule

// ---- bm_regbank.v ----
// Paged register bank of the battery monitor behind an AHB-Lite slave
//
// Behaviour
// RULE1: Page 0 read-only except status and threshold
// RULE2: Status byte retained, writable, steers features; here hresetn reloads bits 3..0 with 4'hf
// RULE3: Bit0 enables current sampling and charge count
// RULE4: Bit1 enables accumulators in page 7 bytes4-7
// RULE5: Bit2 copies accumulators to EEPROM on increment
// RULE6: Shadow bit ignored while accumulators disabled
// RULE7: Bit3 picks supply or aux voltage input
// RULE8: Bit4 shows temperature conversion in progress
// RULE9: Bit5 shows EEPROM copy in progress
// RULE10: Bit6 shows voltage conversion in progress
// RULE11: Page 0 holds temperature, voltage, current results
// RULE12: Operation follows stored status and threshold
// RULE13: Elapsed seconds and charge count host-writable
// RULE14: Page 1 maps seconds, count, offset bytes
// RULE15: Page 1 byte 7 reads all ones
// RULE16: Page 2 holds two writable timestamps
// RULE17: Pages 3-7 are 40 EEPROM bytes
// RULE18: Host avoids page 7 while accumulators run
// RULE19: Elapsed seconds is 32-bit one-second count
// RULE20: Busy bits ignore host writes
`timescale 1ns/1ps
`include "bm_defs.vh"
module bm_regbank
#(
   parameter CUR_CYC    = `BM_CUR_CYC,
   parameter VCONV_CYC  = `BM_VCONV_CYC,
   parameter TCONV_CYC  = `BM_TCONV_CYC,
   parameter NVM_CYC    = `BM_NVM_CYC,
   parameter SECOND_CYC = `BM_SECOND_CYC
)
(
   // AHB-Lite clock and reset
   input  wire         hclk,
   input  wire         hresetn,
   // AHB-Lite slave
   input  wire         hsel,
   input  wire [31:0]  haddr,
   input  wire [1:0]   htrans,
   input  wire         hwrite,
   input  wire [2:0]   hsize,
   input  wire [31:0]  hwdata,
   input  wire         hready,
   output reg          hreadyout,
   output reg  [31:0]  hrdata,
   output reg          hresp,
   // Converter results and events
   input  wire [15:0]  temp_result_in,
   input  wire [15:0]  supply_volt_in,
   input  wire [15:0]  aux_volt_in,
   input  wire [15:0]  current_in,
   input  wire         ica_step,
   input  wire         charge_step,
   input  wire         discharge_step,
   input  wire         disconnect_evt,
   input  wire         end_of_charge_evt,
   // Analog controls
   output wire         cur_adc_en,
   output wire         volt_sel_supply,
   output wire [7:0]   threshold_out
);

   // ****************************************************************
   // State
   // ****************************************************************
   reg  [7:0]  mem [0:63];                 // Page 1 offset, page 2, pages 3-7
   reg  [3:0]  cfg_r;                      // Writable status bits 3..0
   reg  [7:0]  thresh_r;
   reg  [15:0] temp_r;
   reg  [15:0] volt_r;
   reg  [15:0] cur_r;
   reg  [31:0] etm_r;
   reg  [27:0] sec_cnt_r;
   reg  [7:0]  ica_r;
   reg  [15:0] chg_r;
   reg  [15:0] dis_r;
   reg         wr_pend_r;
   reg         rd_pend_r;
   reg  [29:0] waddr_r;
   reg  [7:0]  rd_byte;
   reg         cmd_temp;
   reg         cmd_volt;
   reg         nvm_start;

   wire        temp_busy;
   wire        temp_done;
   wire        volt_busy;
   wire        volt_done;
   wire        nvm_busy;
   wire        cur_busy;
   wire        cur_tick;
   wire        sec_tick;
   wire        acc_on;
   wire        shadow_on;
   wire        in_map;
   wire [5:0]  widx;
   wire [7:0]  wbyte;
   wire        wr_map;
   wire        wr_cmd;
   wire [7:0]  status_byte;
   wire [15:0] chg_nxt;
   wire [15:0] dis_nxt;

   localparam [31:0] SEC_M1   = SECOND_CYC - 1;
   localparam [27:0] SEC_LAST = SEC_M1[27:0];

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   assign in_map = (waddr_r[29:6] == 24'h00_0000);
   assign widx   = waddr_r[5:0];
   assign wbyte  = hwdata[7:0];
   assign wr_map = wr_pend_r & in_map;
   assign wr_cmd = wr_pend_r & (waddr_r == `BM_CMD_WADDR);

   // Feature bits act on the stored byte directly
   assign acc_on    = cfg_r[`BM_CFG_ACC_EN];                          // [RULE12]
   assign shadow_on = acc_on & cfg_r[`BM_CFG_SHADOW];                 // [RULE6]
   assign chg_nxt   = chg_r + 16'h0001;
   assign dis_nxt   = dis_r + 16'h0001;

   // Flags reflect live busy state, never stored host data
   assign status_byte = {1'b0, volt_busy, nvm_busy, temp_busy, cfg_r}; // [RULE8] [RULE9] [RULE10] [RULE20]

   // Outputs straight from configuration flops
   assign cur_adc_en      = cfg_r[`BM_CFG_CUR_EN];                    // [RULE3]
   assign volt_sel_supply = cfg_r[`BM_CFG_VSEL];                      // [RULE7]
   assign threshold_out   = thresh_r;

   // ****************************************************************
   // Timers
   // ****************************************************************
   bm_busy_timer #(.W(28), .CYC(TCONV_CYC)) u_temp_tmr
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (cmd_temp),
      .busy_r  (temp_busy),
      .done_r  (temp_done)
   );

   bm_busy_timer #(.W(28), .CYC(VCONV_CYC)) u_volt_tmr
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (cmd_volt),
      .busy_r  (volt_busy),
      .done_r  (volt_done)
   );

   // Worst-case copy time, so software never sees a copy end early
   bm_busy_timer #(.W(28), .CYC(NVM_CYC)) u_nvm_tmr
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (nvm_start),
      .busy_r  (nvm_busy),
      .done_r  ()
   );

   // Free-running sample period while current sampling is on
   bm_busy_timer #(.W(28), .CYC(CUR_CYC)) u_cur_tmr
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (cfg_r[`BM_CFG_CUR_EN] & ~cur_busy),                  // [RULE3]
      .busy_r  (cur_busy),
      .done_r  (cur_tick)
   );

   assign sec_tick = (sec_cnt_r == SEC_LAST);

   // ****************************************************************
   // Commands and copy triggers
   // ****************************************************************
   always @*
   begin
      cmd_temp  = wr_cmd & hwdata[`BM_CMD_TEMP];
      cmd_volt  = wr_cmd & hwdata[`BM_CMD_VOLT];                      // [RULE7]
      nvm_start = 1'b0;
      // Status byte and user pages are committed to EEPROM
      if (wr_map && (widx == `BM_IDX_STATUS || widx >= `BM_IDX_EE_FIRST))
         nvm_start = 1'b1;                                            // [RULE2] [RULE17] [RULE9]
      if (shadow_on && (charge_step || discharge_step))
         nvm_start = 1'b1;                                            // [RULE5]
   end

   // ****************************************************************
   // AHB-Lite handshake: writes zero-wait, reads one wait state
   // ****************************************************************
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         waddr_r   <= 30'h0000_0000;
         hreadyout <= 1'b1;
         hrdata    <= 32'h0000_0000;
         hresp     <= 1'b0;
      end
      else
      begin
         hresp     <= 1'b0;
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         hreadyout <= 1'b1;
         // The wait state lets a preceding write land before the read
         if (rd_pend_r)
            hrdata <= {24'h00_0000, rd_byte};
         else if (hready && hsel && htrans[1])
         begin
            waddr_r   <= haddr[31:2];
            wr_pend_r <= hwrite;
            rd_pend_r <= ~hwrite;
            hreadyout <= hwrite;
         end
      end
   end

   // ****************************************************************
   // Read mux
   // ****************************************************************
   always @*
   begin
      rd_byte = 8'h00;
      if (in_map)
      begin
         case (widx)
            `BM_IDX_STATUS:  rd_byte = status_byte;
            `BM_IDX_TEMP_LO: rd_byte = temp_r[7:0];                   // [RULE11]
            `BM_IDX_TEMP_HI: rd_byte = temp_r[15:8];
            `BM_IDX_VOLT_LO: rd_byte = volt_r[7:0];
            `BM_IDX_VOLT_HI: rd_byte = volt_r[15:8];
            `BM_IDX_CUR_LO:  rd_byte = cur_r[7:0];
            `BM_IDX_CUR_HI:  rd_byte = cur_r[15:8];
            `BM_IDX_THRESH:  rd_byte = thresh_r;
            `BM_IDX_ICA:     rd_byte = ica_r;                         // [RULE14]
            `BM_IDX_RSVD:    rd_byte = `BM_RSVD_VALUE;                // [RULE15]
            default:
            begin
               if (widx[5:3] == `BM_PAGE1 && widx[2] == 1'b0)
                  rd_byte = etm_r[8*widx[1:0] +: 8];                  // [RULE14]
               else if (acc_on && widx >= `BM_IDX_ACC_FIRST)
               begin
                  case (widx[1:0])                                    // [RULE4]
                     2'h0:    rd_byte = chg_r[7:0];
                     2'h1:    rd_byte = chg_r[15:8];
                     2'h2:    rd_byte = dis_r[7:0];
                     default: rd_byte = dis_r[15:8];
                  endcase
               end
               else
                  rd_byte = mem[widx];                                // [RULE16] [RULE17]
            end
         endcase
      end
   end

   // ****************************************************************
   // Page 0 configuration and results
   // ****************************************************************
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_r    <= `BM_STATUS_RST;
         thresh_r <= 8'h00;
         temp_r   <= 16'h0000;
         volt_r   <= 16'h0000;
         cur_r    <= 16'h0000;
      end
      else
      begin
         // Only the status low nibble and threshold take writes
         if (wr_map && widx == `BM_IDX_STATUS)
            cfg_r <= wbyte[3:0];                                      // [RULE1] [RULE2] [RULE20]
         if (wr_map && widx == `BM_IDX_THRESH)
            thresh_r <= wbyte;                                        // [RULE1]
         // Results change only on completion
         if (temp_done)
            temp_r <= temp_result_in;                                 // [RULE11]
         if (volt_done)
            volt_r <= cfg_r[`BM_CFG_VSEL] ? supply_volt_in : aux_volt_in; // [RULE7] [RULE11]
         if (cur_tick && cfg_r[`BM_CFG_CUR_EN])
            cur_r <= current_in;                                      // [RULE3]
      end
   end

   // ****************************************************************
   // Page 1 counters
   // ****************************************************************
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sec_cnt_r <= 28'h000_0000;
         etm_r     <= 32'h0000_0000;
         ica_r     <= 8'h00;
      end
      else
      begin
         sec_cnt_r <= sec_tick ? 28'h000_0000 : sec_cnt_r + 28'h000_0001;
         if (sec_tick)
            etm_r <= etm_r + 32'h0000_0001;                           // [RULE19]
         // A host write replaces the byte even on a tick
         if (wr_map && widx[5:3] == `BM_PAGE1 && widx[2] == 1'b0)
            etm_r[8*widx[1:0] +: 8] <= wbyte;                         // [RULE13]
         if (wr_map && widx == `BM_IDX_ICA)
            ica_r <= wbyte;                                           // [RULE13]
         else if (ica_step && cfg_r[`BM_CFG_CUR_EN])
            ica_r <= ica_r + 8'h01;                                   // [RULE3]
      end
   end

   // ****************************************************************
   // Accumulators in page 7 bytes 4-7
   // ****************************************************************
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         chg_r <= 16'h0000;
         dis_r <= 16'h0000;
      end
      else
      begin
         if (acc_on && charge_step)
            chg_r <= chg_nxt;                                         // [RULE4]
         if (acc_on && discharge_step)
            dis_r <= dis_nxt;
         // Host write clobbers the running totals
         if (wr_map && widx >= `BM_IDX_ACC_FIRST)
         begin
            case (widx[1:0])                                          // [RULE18]
               2'h0:    chg_r[7:0]  <= wbyte;
               2'h1:    chg_r[15:8] <= wbyte;
               2'h2:    dis_r[7:0]  <= wbyte;
               default: dis_r[15:8] <= wbyte;
            endcase
         end
      end
   end

   // ****************************************************************
   // Byte storage: offset, timestamps, EEPROM pages (no reset: retained)
   // ****************************************************************
   always @(posedge hclk)
   begin
      if (wr_map && widx > `BM_IDX_ICA && widx != `BM_IDX_RSVD)
         mem[widx] <= wbyte;                                          // [RULE14] [RULE16] [RULE17]
      // Hardware timestamp capture wins over a host write
      if (disconnect_evt)
      begin
         mem[`BM_IDX_DISC]        <= etm_r[7:0];                      // [RULE16]
         mem[`BM_IDX_DISC + 6'h1] <= etm_r[15:8];
         mem[`BM_IDX_DISC + 6'h2] <= etm_r[23:16];
         mem[`BM_IDX_DISC + 6'h3] <= etm_r[31:24];
      end
      if (end_of_charge_evt)
      begin
         mem[`BM_IDX_EOC]        <= etm_r[7:0];
         mem[`BM_IDX_EOC + 6'h1] <= etm_r[15:8];
         mem[`BM_IDX_EOC + 6'h2] <= etm_r[23:16];
         mem[`BM_IDX_EOC + 6'h3] <= etm_r[31:24];
      end
      // Shadow copy of the incremented totals
      if (shadow_on && charge_step)
      begin
         mem[`BM_IDX_ACC_FIRST]        <= chg_nxt[7:0];               // [RULE5]
         mem[`BM_IDX_ACC_FIRST + 6'h1] <= chg_nxt[15:8];
      end
      if (shadow_on && discharge_step)
      begin
         mem[`BM_IDX_ACC_FIRST + 6'h2] <= dis_nxt[7:0];
         mem[`BM_IDX_ACC_FIRST + 6'h3] <= dis_nxt[15:8];
      end
   end

endmodule

// ---- bm_regbank_asserts.sv ----
// Concurrent checks on the ports of the battery monitor bank
`timescale 1ns/1ps
module bm_regbank_chk
(
   // Clock and reset
   input wire        hclk,
   input wire        hresetn,
   // Bus
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire [31:0] hrdata,
   input wire        hresp,
   // Analog controls
   input wire        cur_adc_en,
   input wire        volt_sel_supply,
   input wire [7:0]  threshold_out
);
   logic taken;
   logic rd_r;
   logic wr_r;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ****************************************************************
   // Data phase trackers
   // ****************************************************************
   assign taken = hsel && hready && htrans[1];
   // Cleared in reset so no stale phase survives
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_r <= 1'b0;
         wr_r <= 1'b0;
      end
      else
      begin
         rd_r <= taken && !hwrite;
         wr_r <= taken && hwrite;
      end
   end
   // ****************************************************************
   // Properties
   // ****************************************************************
   property p_rd;
      taken && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd: assert property (p_rd)
      else $error("read wait state wrong");
   property p_wr;
      taken && hwrite |=> hreadyout;
   endproperty
   a_wr: assert property (p_wr)
      else $error("write was stalled");
   property p_wait;
      !hreadyout |-> rd_r;
   endproperty
   a_wait: assert property (p_wait)
      else $error("stall without a read");
   property p_resp;
      hresp == 1'b0;
   endproperty
   a_resp: assert property (p_resp)
      else $error("error response seen");
   property p_hi;
      hrdata[31:8] == 24'h0;
   endproperty
   a_hi: assert property (p_hi)
      else $error("upper read bits set");
   // Controls may only move in the three cycles after a write address phase
   property p_thr;
      $changed(threshold_out) |-> wr_r || $past(wr_r) || $past(wr_r, 2);
   endproperty
   a_thr: assert property (p_thr)
      else $error("threshold moved without write");
   property p_cur;
      $changed(cur_adc_en) |-> wr_r || $past(wr_r) || $past(wr_r, 2);
   endproperty
   a_cur: assert property (p_cur)
      else $error("current enable moved without write");
   property p_vsel;
      $changed(volt_sel_supply) |-> wr_r || $past(wr_r) || $past(wr_r, 2);
   endproperty
   a_vsel: assert property (p_vsel)
      else $error("input select moved without write");
endmodule

// ---- bm_afe_model.sv ----
// Analog front-end stand-in: samples that step by one per request and one event pulse per request
`timescale 1ns/1ps
module bm_afe_model
(
   // Clock
   input  wire         hclk,
   // Request from bench
   input  wire         go,
   // Samples and events
   output wire [15:0]  temp_v,
   output wire [15:0]  sup_v,
   output wire [15:0]  aux_v,
   output wire [15:0]  cur_v,
   output reg          step_r
);
   reg [15:0] n_r = 16'h0000;
   // Distinct samples so a wrong source shows at once; each request moves them
   assign temp_v = 16'h1234 + n_r;
   assign sup_v  = 16'h5678 + n_r;
   assign aux_v  = 16'h9abc + n_r;
   assign cur_v  = 16'hdef0 + n_r;
   // Pulse is sent ungated: gating by the enables is the device's job
   always @(posedge hclk)
   begin
      step_r <= go;
      if (go)
         n_r <= n_r + 16'h0001;
   end
endmodule

// ---- tb_battery_monitor_memory_pages.sv ----
// Self-checking bench for the battery monitor register bank
`timescale 1ns/1ps
module tb_battery_monitor_memory_pages;
   logic        hclk    = 1'b0;
   logic        hresetn = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0;
   logic        go      = 1'b0;
   logic [31:0] q;
   wire         hreadyout;
   wire [31:0]  hrdata;
   wire         hresp;
   wire         step;
   wire         cur_adc_en;
   wire         volt_sel_supply;
   wire [7:0]   threshold_out;
   wire [15:0]  temp_v;
   wire [15:0]  sup_v;
   wire [15:0]  aux_v;
   wire [15:0]  cur_v;
   int          err_total   = 0;
   int          comparisons = 0;
   logic [11:0] ta [4] = '{12'h050, 12'h060, 12'h0ec, 12'h104};
   // ****************************************************************
   // Clock, design and front end
   // ****************************************************************
   always #2.5 hclk = ~hclk;
   bm_regbank #(.CUR_CYC(16), .VCONV_CYC(12), .TCONV_CYC(10), .NVM_CYC(8), .SECOND_CYC(20)) i_dut
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .temp_result_in(temp_v), .supply_volt_in(sup_v), .aux_volt_in(aux_v),
      .current_in(cur_v), .ica_step(step), .charge_step(step), .discharge_step(step),
      .disconnect_evt(step), .end_of_charge_evt(step), .cur_adc_en(cur_adc_en),
      .volt_sel_supply(volt_sel_supply), .threshold_out(threshold_out)
   );
   bm_afe_model i_afe
   (
      .hclk(hclk), .go(go), .temp_v(temp_v), .sup_v(sup_v), .aux_v(aux_v), .cur_v(cur_v), .step_r(step)
   );
   // ****************************************************************
   // Tasks
   // ****************************************************************
   // One single transfer; only the watchdog ends a wait
   task automatic ahb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge hclk);
      haddr  <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic rc(input logic [11:0] a, input logic [7:0] e);
      ahb(1'b0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask
   // Ask the front end for one event pulse
   task automatic kick;
      @(posedge hclk);
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rc(12'h000, 8'h0f);
      chk(cur_adc_en, 1'b1);
      chk(volt_sel_supply, 1'b1);
      wr(12'h01c, 8'ha5);
      rc(12'h01c, 8'ha5);
      chk(threshold_out, 8'ha5);
      wr(12'h004, 8'h55);
      rc(12'h004, 8'h00);
      rc(12'h03c, 8'hff);
      $display("test reset and access done");
      // Both conversions at once, supply input selected
      wr(12'h100, 8'h03);
      rc(12'h000, 8'h5f);
      repeat (20) @(posedge hclk);
      rc(12'h000, 8'h0f);
      rc(12'h004, 8'h34);
      rc(12'h008, 8'h12);
      rc(12'h00c, 8'h78);
      rc(12'h010, 8'h56);
      // Busy bits written high must not stick
      wr(12'h000, 8'hf2);
      rc(12'h000, 8'h22);
      chk(cur_adc_en, 1'b0);
      chk(volt_sel_supply, 1'b0);
      wr(12'h100, 8'h02);
      repeat (20) @(posedge hclk);
      rc(12'h00c, 8'hbc);
      rc(12'h000, 8'h02);
      $display("test conversions done");
      wr(12'h030, 8'h10);
      kick;
      rc(12'h030, 8'h10);
      // Page 7 left unwritten while totals run
      wr(12'h000, 8'h07);
      repeat (12) @(posedge hclk);
      rc(12'h0f0, 8'h01);
      kick;
      rc(12'h000, 8'h27);
      rc(12'h030, 8'h11);
      rc(12'h0f0, 8'h02);
      wr(12'h000, 8'h05);
      wr(12'h0f0, 8'h33);
      repeat (12) @(posedge hclk);
      kick;
      rc(12'h000, 8'h05);
      rc(12'h0f0, 8'h33);
      $display("test accumulators done");
      // Carry through all four bytes on the next tick
      wr(12'h02c, 8'h00);
      wr(12'h028, 8'hff);
      wr(12'h024, 8'hff);
      wr(12'h020, 8'hff);
      repeat (25) @(posedge hclk);
      rc(12'h02c, 8'h01);
      kick;
      rc(12'h04c, 8'h01);
      rc(12'h030, 8'h13);
      // Last entry is outside the map and must read zero
      for (int i = 0; i < 4; i++)
      begin
         wr(ta[i], 8'(8'ha0 + i));
         rc(ta[i], (ta[i] == 12'h104) ? 8'h00 : 8'(8'ha0 + i));
      end
      // Four requests moved the current sample to def4
      rc(12'h014, 8'hf4);
      rc(12'h018, 8'hde);
      $display("test time and storage done");
      summarize;
   end
   // Guard against a hung handshake
   initial
   begin
      #20000;
      err_total++;
      summarize;
   end
endmodule
bind bm_regbank bm_regbank_chk i_chk
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cur_adc_en(cur_adc_en),
   .volt_sel_supply(volt_sel_supply), .threshold_out(threshold_out)
);
